// *** aio_bus_if.sv ***
// Bus-side control of the analog input/output card: decode, sequencer, status and output buffers
`timescale 1ns/1ps
module aio_bus_if #(
    parameter int P_CONV_CYCLES = aio_pkg::CONV_CYCLES
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    // Backplane and jumpers
    input wire aio_pkg::aio_bus_t i_bus,
    input wire aio_pkg::aio_strap_t i_strap,
    output logic [7:0] o_data,
    output logic o_data_oe,
    output logic o_wait_n,
    output logic o_wait_n_oe,
    output logic o_intrq_n,
    output logic o_intrq_n_oe,
    // Input converter side
    input wire logic [11:0] i_adc_result,
    output logic [4:0] o_channel_sel,
    output logic [1:0] o_gain_sel,
    output logic o_sh_hold,
    output logic o_conv_start,
    // Output converters
    output logic [11:0] o_out0,
    output logic [11:0] o_out1
);
    import aio_pkg::*;

    // Two-stage synchronisers for every backplane and jumper pin
    aio_bus_t bus_s1;
    aio_bus_t bus_s2;
    aio_strap_t strap_s1;
    aio_strap_t strap_s2;
    logic clk_q; // Previous synced bus clock level

    // Main state
    aio_conv_state_t state, next_state;
    logic [CNT_W-1:0] cnt, next_cnt; // Sequencer cycle count
    logic acc_q, next_acc_q; // Access seen last cycle
    logic pending, next_pending; // End-of-conversion flag
    logic [11:0] result, next_result; // Last conversion result
    logic [7:0] out0_lo, next_out0_lo; // Buffered low bytes
    logic [3:0] out0_hi, next_out0_hi; // Buffered high nibble
    logic [7:0] out1_lo, next_out1_lo;
    logic wait_act, next_wait_act; // Wait state in progress
    logic [7:0] next_data;
    logic next_data_oe;
    logic [4:0] next_chan;
    logic [1:0] next_gain;
    logic next_start;
    logic [11:0] next_out0, next_out1;

    // Decoded access
    logic hit; // Address falls on this card
    logic acc; // Strobe active on a hit
    logic acc_start; // First cycle of an access
    logic rd_start, wr_start;
    logic [3:0] ofs;
    logic conv_end; // Last sequencer cycle

    // Claim decision for one address and qualifier set
    function automatic logic f_hit(input logic [15:0] a, input aio_strap_t s, input logic ioexp,
                                   input logic memex_n);
        logic ok;
        ok = 1'b1;
        if (a[OFS_UNDECODED_BIT]) begin
            ok = 1'b0;
        end
        if (s.mem_mode || s.addr16) begin
            ok = ok && (a[15:4] == s.base);
        end else begin
            ok = ok && (a[7:4] == s.base[7:4]);
        end
        if (s.mem_mode) begin
            ok = ok && !(s.memex_en && memex_n);
        end else if (s.ioexp_mode == IOEXP_HIGH) begin
            ok = ok && ioexp;
        end else if (s.ioexp_mode == IOEXP_LOW) begin
            ok = ok && !ioexp;
        end
        return ok;
    endfunction : f_hit

    // Pin synchronisers; only the second stage is read
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            bus_s1 <= '1;
            bus_s2 <= '1;
            strap_s1 <= '0;
            strap_s2 <= '0;
            // Matches the synced reset level so no false bus clock edge follows reset
            clk_q <= 1'b1;
        end else begin
            bus_s1 <= i_bus;
            bus_s2 <= bus_s1;
            strap_s1 <= i_strap;
            strap_s2 <= strap_s1;
            clk_q <= bus_s2.bus_clk;
        end
    end

    // Address decode and access edge
    always_comb begin
        ofs = bus_s2.addr[3:0];
        hit = f_hit(bus_s2.addr, strap_s2, bus_s2.ioexp, bus_s2.memex_n);
        acc = hit && (strap_s2.mem_mode ? !bus_s2.memrq_n : !bus_s2.iorq_n) &&
              (!bus_s2.rd_n || !bus_s2.wr_n);
        acc_start = acc && !acc_q;
        rd_start = acc_start && !bus_s2.rd_n;
        wr_start = acc_start && !bus_s2.wr_n;
        conv_end = (state == CS_CONVERT) && (cnt == CNT_W'(P_CONV_CYCLES - 1));
    end

    // Next values of all card state
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_acc_q = acc;
        next_pending = pending;
        next_result = result;
        next_out0_lo = out0_lo;
        next_out0_hi = out0_hi;
        next_out1_lo = out1_lo;
        next_chan = o_channel_sel;
        next_gain = o_gain_sel;
        next_start = 1'b0;
        next_out0 = o_out0;
        next_out1 = o_out1;
        next_wait_act = wait_act;
        next_data = RST_BYTE;
        next_data_oe = 1'b0;
        // Sequencer: hold first, then convert, result at the end
        case (state)
            CS_IDLE: begin
                next_cnt = '0;
            end
            CS_HOLD: begin
                next_cnt = cnt + 1'b1;
                if (cnt == CNT_W'(SH_SETTLE_CYCLES - 1)) begin
                    next_state = CS_CONVERT;
                    next_start = 1'b1;
                end
            end
            CS_CONVERT: begin
                next_cnt = cnt + 1'b1;
                if (conv_end) begin
                    next_state = CS_IDLE;
                    next_result = i_adc_result;
                    next_pending = 1'b1;
                end
            end
            default: begin
                next_state = CS_IDLE;
                next_cnt = '0;
            end
        endcase
        // Low byte read clears pending; a coincident end still sets it
        if (rd_start && ofs == OFS_RES_LO && !conv_end) begin
            next_pending = 1'b0;
        end
        // Register writes
        if (wr_start) begin
            case (ofs)
                OFS_CHAN_GAIN: begin
                    next_chan = bus_s2.data[CHAN_LSB +: CHAN_W];
                    next_gain = {bus_s2.data[GAIN_HI_BIT], bus_s2.data[GAIN_LO_BIT]};
                    next_state = CS_HOLD;
                    next_cnt = '0;
                    // A restart drops a start pulse due in this same cycle
                    next_start = 1'b0;
                end
                OFS_OUT0_LO: next_out0_lo = bus_s2.data;
                OFS_OUT0_HI: next_out0_hi = bus_s2.data[3:0];
                OFS_OUT1_LO: next_out1_lo = bus_s2.data;
                OFS_OUT1_HI: begin
                    // Both converters load in the same cycle
                    next_out0 = {out0_hi, out0_lo};
                    next_out1 = {bus_s2.data[3:0], out1_lo};
                end
                default: begin
                end
            endcase
        end
        // Read data, driven for the whole strobe
        if (acc && !bus_s2.rd_n) begin
            case (ofs)
                OFS_RES_LO: begin
                    next_data = result[7:0];
                    next_data_oe = 1'b1;
                end
                OFS_RES_HI: begin
                    // Busy in bit 7, pending in bit 6, unused bits read zero
                    next_data = {state != CS_IDLE, pending, 2'b00, result[11:8]};
                    next_data_oe = 1'b1;
                end
                OFS_UNUSED: begin
                    next_data = RST_BYTE;
                    next_data_oe = 1'b1;
                end
                default: begin
                end
            endcase
        end
        // One wait state: hold off until the next bus clock rise
        if (acc_start && strap_s2.wait_en) begin
            next_wait_act = 1'b1;
        end else if (wait_act && bus_s2.bus_clk && !clk_q) begin
            next_wait_act = 1'b0;
        end
    end

    // State registers and registered outputs
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            state <= CS_IDLE;
            cnt <= '0;
            acc_q <= 1'b0;
            pending <= 1'b0;
            result <= RST_OUT;
            out0_lo <= RST_BYTE;
            out0_hi <= 4'h0;
            out1_lo <= RST_BYTE;
            wait_act <= 1'b0;
            o_data <= RST_BYTE;
            o_data_oe <= 1'b0;
            o_wait_n <= 1'b1;
            o_wait_n_oe <= 1'b0;
            o_intrq_n <= 1'b1;
            o_intrq_n_oe <= 1'b0;
            o_channel_sel <= RST_CHAN;
            o_gain_sel <= GAIN_X1;
            o_sh_hold <= 1'b0;
            o_conv_start <= 1'b0;
            o_out0 <= RST_OUT;
            o_out1 <= RST_OUT;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            acc_q <= next_acc_q;
            pending <= next_pending;
            result <= next_result;
            out0_lo <= next_out0_lo;
            out0_hi <= next_out0_hi;
            out1_lo <= next_out1_lo;
            wait_act <= next_wait_act;
            o_data <= next_data;
            o_data_oe <= next_data_oe;
            o_wait_n <= !next_wait_act;
            o_wait_n_oe <= next_wait_act;
            // Open drain: pulled low only while pending and strapped on
            o_intrq_n <= !(next_pending && strap_s2.irq_en);
            o_intrq_n_oe <= next_pending && strap_s2.irq_en;
            o_channel_sel <= next_chan;
            o_gain_sel <= next_gain;
            o_sh_hold <= next_state != CS_IDLE;
            o_conv_start <= next_start;
            o_out0 <= next_out0;
            o_out1 <= next_out1;
        end
    end

    // Checks on the card behaviour
    property p_no_upper_claim;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        bus_s2.addr[OFS_UNDECODED_BIT] |-> !acc_start && !o_data_oe;
    endproperty
    a_no_upper_claim: assert property (p_no_upper_claim) else $error("upper offset claimed");

    property p_ioexp_high;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (!strap_s2.mem_mode && strap_s2.ioexp_mode == IOEXP_HIGH && !bus_s2.ioexp) |-> !hit;
    endproperty
    a_ioexp_high: assert property (p_ioexp_high) else $error("IOEXP qualifier ignored");

    property p_chan_write;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (wr_start && ofs == OFS_CHAN_GAIN) |=> o_channel_sel == $past(bus_s2.data[4:0]) && o_sh_hold
            && cnt == '0;
    endproperty
    a_chan_write: assert property (p_chan_write) else $error("channel write not taken");

    property p_conv_end;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (conv_end && !wr_start) |=> state == CS_IDLE && pending && result == $past(i_adc_result);
    endproperty
    a_conv_end: assert property (p_conv_end) else $error("conversion end mishandled");

    property p_conv_len;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (state != CS_IDLE) |-> cnt < CNT_W'(P_CONV_CYCLES);
    endproperty
    a_conv_len: assert property (p_conv_len) else $error("conversion overran");

    property p_lo_clears;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (rd_start && ofs == OFS_RES_LO && !conv_end) |=> !pending ##1 o_data_oe;
    endproperty
    a_lo_clears: assert property (p_lo_clears) else $error("pending not cleared");

    property p_busy_read;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (acc && !bus_s2.rd_n && ofs == OFS_RES_HI) |=> o_data[BUSY_BIT] == ($past(state) != CS_IDLE)
            && o_data[PEND_BIT] == $past(pending) && o_data[5:4] == 2'b00;
    endproperty
    a_busy_read: assert property (p_busy_read) else $error("status byte wrong");

    property p_update;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (wr_start && ofs == OFS_OUT1_HI) |=> o_out0 == {$past(out0_hi), $past(out0_lo)}
            && o_out1[7:0] == $past(out1_lo);
    endproperty
    a_update: assert property (p_update) else $error("outputs not updated together");

    property p_hold_out;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        !(wr_start && ofs == OFS_OUT1_HI) |=> $stable(o_out0) && $stable(o_out1);
    endproperty
    a_hold_out: assert property (p_hold_out) else $error("output changed without update");

    property p_wait;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (acc_start && strap_s2.wait_en) |=> o_wait_n_oe && !o_wait_n;
    endproperty
    a_wait: assert property (p_wait) else $error("wait state missing");

    property p_intrq;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        o_intrq_n_oe == (pending && $past(strap_s2.irq_en)) && o_intrq_n == !o_intrq_n_oe;
    endproperty
    a_intrq: assert property (p_intrq) else $error("interrupt line disagrees with pending");

    property p_start_pulse;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        o_conv_start |-> state == CS_CONVERT && cnt == CNT_W'(SH_SETTLE_CYCLES) && o_sh_hold;
    endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("converter start out of place");

    property p_gain_write;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (wr_start && ofs == OFS_CHAN_GAIN) |=> o_gain_sel == {$past(bus_s2.data[GAIN_HI_BIT]),
            $past(bus_s2.data[GAIN_LO_BIT])};
    endproperty
    a_gain_write: assert property (p_gain_write) else $error("gain write not taken");

    property p_lo_read;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (acc && !bus_s2.rd_n && ofs == OFS_RES_LO) |=> o_data_oe && o_data == $past(result[7:0]);
    endproperty
    a_lo_read: assert property (p_lo_read) else $error("low result byte wrong");
endmodule : aio_bus_if

// *** aio_pkg.sv ***
// Package: offsets, fields, reset values, timing and carrier types of the analog I/O bus block
package aio_pkg;
    // Clock and conversion timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int CONV_TIME_US = 125;
    localparam int CONV_CYCLES = (CONV_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int SH_SETTLE_NS = 2000;
    localparam int SH_SETTLE_CYCLES = (SH_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 16;

    // Register offsets within the claimed window
    localparam logic [3:0] OFS_CHAN_GAIN = 4'h0;
    localparam logic [3:0] OFS_RES_LO = 4'h1;
    localparam logic [3:0] OFS_RES_HI = 4'h2;
    localparam logic [3:0] OFS_UNUSED = 4'h3;
    localparam logic [3:0] OFS_OUT0_LO = 4'h4;
    localparam logic [3:0] OFS_OUT0_HI = 4'h5;
    localparam logic [3:0] OFS_OUT1_LO = 4'h6;
    localparam logic [3:0] OFS_OUT1_HI = 4'h7;
    localparam int OFS_UNDECODED_BIT = 3;

    // Field positions
    localparam int CHAN_LSB = 0;
    localparam int CHAN_W = 5;
    localparam int GAIN_LO_BIT = 5;
    localparam int GAIN_HI_BIT = 6;
    localparam int PEND_BIT = 6;
    localparam int BUSY_BIT = 7;

    // Gain codes and decode qualifier modes
    localparam logic [1:0] GAIN_X1 = 2'h0;
    localparam logic [1:0] GAIN_X10 = 2'h1;
    localparam logic [1:0] GAIN_X100 = 2'h2;
    localparam logic [1:0] IOEXP_IGNORE = 2'h0;
    localparam logic [1:0] IOEXP_HIGH = 2'h1;
    localparam logic [1:0] IOEXP_LOW = 2'h2;

    // Reset values
    localparam logic [11:0] RST_OUT = 12'h000;
    localparam logic [4:0] RST_CHAN = 5'h00;
    localparam logic [7:0] RST_BYTE = 8'h00;

    // Backplane pins as seen by the card
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] data;
        logic rd_n;
        logic wr_n;
        logic iorq_n;
        logic memrq_n;
        logic ioexp;
        logic memex_n;
        logic bus_clk;
    } aio_bus_t;

    // Jumper straps
    typedef struct packed {
        logic [15:4] base;
        logic mem_mode;
        logic addr16;
        logic [1:0] ioexp_mode;
        logic memex_en;
        logic wait_en;
        logic irq_en;
    } aio_strap_t;

    // Conversion sequencer states
    typedef enum logic [1:0] {
        CS_IDLE,
        CS_HOLD,
        CS_CONVERT
    } aio_conv_state_t;
endpackage : aio_pkg

// *** aio_host_mdl.sv ***
// Bus master model of the CPU card that drives the backplane
`timescale 1ns/1ps
module aio_host_mdl
    import aio_pkg::*;
(
    // Clock and card answer
    input wire logic i_clk_sys,
    input wire logic i_wait_n,
    input wire logic [7:0] i_data,
    input wire logic i_data_oe,
    // Backplane pins
    output aio_pkg::aio_bus_t o_bus
);
    logic mem_sel = 1'b0; // Memory cycles when set
    logic saw_wait = 1'b0; // Wait seen during last access
    logic [1:0] div = 2'h0; // Bus clock divider
    int n_hang = 0; // Accesses whose wait never ended

    // Idle bus: strobes high, memex inactive
    initial o_bus = {16'h0000, 8'h00, 7'b1111010};

    // Bus clock runs free at an eighth of the system rate
    always @(negedge i_clk_sys) begin
        div <= div + 2'h1;
        if (div == 2'h3) begin
            o_bus.bus_clk <= ~o_bus.bus_clk;
        end
    end

    // One access: pins held until the wait line is high again
    task automatic xfer(input logic wr, input logic [15:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic ans);
        int n;
        n = 0;
        @(negedge i_clk_sys);
        o_bus.addr = a;
        o_bus.data = wr ? d : ~o_bus.data; // Released data never keeps its last value
        if (mem_sel) begin
            o_bus.memrq_n = 1'b0;
        end else begin
            o_bus.iorq_n = 1'b0;
        end
        o_bus.wr_n = !wr;
        o_bus.rd_n = wr;
        saw_wait = 1'b0;
        // Card sees pins two edges late; give it time before looking
        repeat (5) begin
            @(posedge i_clk_sys);
            saw_wait |= !i_wait_n;
        end
        while (!i_wait_n && n < 40) begin
            @(posedge i_clk_sys);
            n++;
        end
        if (n == 40) begin
            n_hang++;
        end
        // An undriven data bus never shows what the card last put on it
        q = i_data_oe ? i_data : ~i_data;
        ans = i_data_oe;
        @(negedge i_clk_sys);
        o_bus[6:3] = 4'hF;
        repeat (3) @(negedge i_clk_sys);
    endtask : xfer
endmodule : aio_host_mdl

// *** tb_top.sv ***
// Self-checking bench of the analog I/O bus block
`timescale 1ns/1ps
module tb_top;
    import aio_pkg::*;
    `define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; \
        $display("unexpected at %0t: got %0h expected %0h", $time, g, e); end end
    localparam int PCONV = 400; // Shortened conversion
    localparam logic [15:0] BASE = 16'h5A30; // Card window
    logic i_clk_sys = 1'b0;
    logic i_resetn = 1'b0;
    aio_strap_t strap; // Jumpers
    aio_bus_t bus;
    logic [11:0] adc = 12'hA5C; // Converter code
    logic [7:0] o_data;
    logic o_data_oe, o_wait_n, o_wait_n_oe, o_intrq_n, o_intrq_n_oe;
    logic [4:0] o_channel_sel;
    logic [1:0] o_gain_sel;
    logic o_sh_hold, o_conv_start, hold_q;
    logic [11:0] o_out0, o_out1;
    int n_fail = 0, check_count = 0, cyc = 0, hold_len = 0, n_start = 0;
    wire logic wait_line = o_wait_n_oe ? o_wait_n : 1'b1; // Pulled up

    always #5 i_clk_sys = ~i_clk_sys;

    aio_bus_if #(.P_CONV_CYCLES(PCONV)) DUT (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
        .i_bus(bus), .i_strap(strap), .o_data(o_data), .o_data_oe(o_data_oe),
        .o_wait_n(o_wait_n), .o_wait_n_oe(o_wait_n_oe), .o_intrq_n(o_intrq_n),
        .o_intrq_n_oe(o_intrq_n_oe), .i_adc_result(adc), .o_channel_sel(o_channel_sel),
        .o_gain_sel(o_gain_sel), .o_sh_hold(o_sh_hold), .o_conv_start(o_conv_start),
        .o_out0(o_out0), .o_out1(o_out1));

    aio_host_mdl MDL (.i_clk_sys(i_clk_sys), .i_wait_n(wait_line), .i_data(o_data),
        .i_data_oe(o_data_oe), .o_bus(bus));

    // Hold length and start pulses, plus the hang guard
    always @(posedge i_clk_sys) begin
        hold_len <= (o_sh_hold && !hold_q) ? 1 : hold_len + int'(o_sh_hold);
        hold_q <= o_sh_hold;
        n_start <= n_start + int'(o_conv_start);
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            tally_and_finish();
        end
    end

    task automatic wr(input logic [3:0] o, input logic [7:0] d);
        logic [7:0] q;
        logic a;
        MDL.xfer(1'b1, BASE + 16'(o), d, q, a);
    endtask : wr

    task automatic rd(input logic [15:0] adr, output logic [7:0] q, output logic a);
        MDL.xfer(1'b0, adr, 8'h00, q, a);
    endtask : rd

    // Let a jumper or pin change pass the synchronisers, then probe
    task automatic probe(input logic [15:0] adr, input logic e);
        logic [7:0] q;
        logic a;
        repeat (4) @(negedge i_clk_sys);
        rd(adr, q, a);
        `CHK(a, e)
    endtask : probe

    // Bounded wait for the sequence to finish
    task automatic wait_idle();
        int n;
        n = 0;
        while (o_sh_hold && n < 2000) begin
            @(negedge i_clk_sys);
            n++;
        end
        `CHK(o_sh_hold, 1'b0)
        repeat (2) @(negedge i_clk_sys);
    endtask : wait_idle

    task automatic tally_and_finish();
        $display("checks %0d failures %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        logic [7:0] q;
        logic a;
        logic [4:0] ch;
        int s0;
        logic [1:0] gc [3];
        gc = '{GAIN_X1, GAIN_X10, GAIN_X100};
        // base, mem, addr16, ioexp mode, memex, wait, irq
        strap = {12'h5A3, 1'b0, 1'b0, IOEXP_IGNORE, 1'b0, 1'b1, 1'b1};
        repeat (5) @(negedge i_clk_sys);
        i_resetn = 1'b1;
        repeat (2) @(negedge i_clk_sys);
        `CHK({o_out0, o_out1, o_channel_sel, o_gain_sel, o_sh_hold}, 32'h0)
        // Every gain code, channels 31, 18 and 5, bit 7 set and ignored
        for (int g = 0; g < 3; g++) begin
            ch = 5'(31 - g * 13);
            wr(OFS_CHAN_GAIN, {1'b1, gc[g], ch});
            `CHK(o_channel_sel, ch)
            `CHK(o_gain_sel, gc[g])
            `CHK(o_sh_hold, 1'b1)
        end
        wait_idle();
        // One clean conversion
        rd(BASE + 16'h1, q, a);
        s0 = n_start;
        wr(OFS_CHAN_GAIN, 8'h25);
        `CHK(MDL.saw_wait, 1'b1)
        rd(BASE + 16'h2, q, a);
        `CHK({a, q[BUSY_BIT], q[PEND_BIT]}, 3'b110)
        wait_idle();
        `CHK(hold_len >= PCONV - 8 && hold_len <= PCONV, 1'b1)
        `CHK(n_start - s0, 1)
        `CHK({o_intrq_n_oe, o_intrq_n}, 2'b10)
        strap.irq_en = 1'b0;
        repeat (4) @(negedge i_clk_sys);
        `CHK({o_intrq_n_oe, o_intrq_n}, 2'b01)
        strap.irq_en = 1'b1;
        repeat (4) @(negedge i_clk_sys);
        `CHK({o_intrq_n_oe, o_intrq_n}, 2'b10)
        rd(BASE + 16'h2, q, a);
        `CHK(q, 8'h4A)
        rd(BASE + 16'h1, q, a);
        `CHK(q, 8'h5C)
        rd(BASE + 16'h2, q, a);
        `CHK(q, 8'h0A)
        `CHK({o_intrq_n_oe, o_intrq_n}, 2'b01)
        // Double-buffered outputs: nothing moves before offset 7
        wr(OFS_OUT0_LO, 8'h34);
        wr(OFS_OUT0_HI, 8'hF2);
        wr(OFS_OUT1_LO, 8'h78);
        `CHK({o_out0, o_out1}, 24'h0)
        wr(OFS_OUT1_HI, 8'hE5);
        `CHK({o_out0, o_out1}, 24'h234578)
        wr(OFS_OUT0_LO, 8'h11);
        `CHK(o_out0, 12'h234)
        // Void, undecoded and write-only places
        rd(BASE + 16'h3, q, a);
        `CHK({a, q}, 9'h100)
        probe(BASE + 16'h9, 1'b0);
        probe(BASE + 16'hF, 1'b0);
        probe(BASE, 1'b0);
        probe(BASE + 16'h10, 1'b0);
        probe(16'h7731, 1'b1);
        strap.addr16 = 1'b1;
        probe(16'h7731, 1'b0);
        strap.ioexp_mode = IOEXP_HIGH;
        probe(BASE + 16'h1, 1'b0);
        MDL.o_bus.ioexp = 1'b1;
        probe(BASE + 16'h1, 1'b1);
        strap.ioexp_mode = IOEXP_LOW;
        probe(BASE + 16'h1, 1'b0);
        strap.mem_mode = 1'b1;
        strap.memex_en = 1'b1;
        strap.wait_en = 1'b0;
        probe(BASE + 16'h1, 1'b0);
        MDL.mem_sel = 1'b1;
        probe(BASE + 16'h1, 1'b0);
        MDL.o_bus.memex_n = 1'b0;
        probe(BASE + 16'h1, 1'b1);
        `CHK(MDL.saw_wait, 1'b0)
        `CHK(MDL.n_hang, 0)
        tally_and_finish();
    end
endmodule : tb_top
